// ==== tmr_slave_ctrl.sv ====
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
module tmr_slave_ctrl
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire tmr_slave_pkg::pins_t pins_in,
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic trigger_output_out,
  output logic trigger_irq_out,
  output logic trigger_dma_out,
  output logic ch2_output_out,
  output logic [3:0] channel_output_enable_out,
  output logic [11:0] channel_output_mode_out
);
  import tmr_slave_pkg::*;

  // ****************************************************
  // Registers
  // ****************************************************
  logic [9:0] ctrl;
  logic [15:0] slave;
  logic [31:0] chan;
  logic [1:0] status;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] psc;
  logic [CNT_W-1:0] psc_cnt;
  logic [CNT_W-1:0] ar;
  logic [CNT_W-1:0] ar_shadow;
  logic [CNT_W-1:0] cmp2;
  logic [CNT_W-1:0] cmp2_shadow;
  logic [CNT_W-1:0] cap1;
  logic sw_update;

  wire [2:0] slave_mode_select = slave[B_SMS +: 3];
  wire [2:0] trigger_source_select = slave[B_TRGS +: 3];
  wire [3:0] ext_trigger_filter = slave[B_EXT_TRIGGER_FILTER +: 4];
  wire [1:0] ext_trigger_divider = slave[B_ETD +: 2];
  wire ext_trigger_polarity = slave[B_ETP];
  wire ext_clock2_enable = slave[B_ECLK];
  wire [1:0] ch1_direction_select = chan[B_CH1_DIRECTION_SELECT +: 2];
  wire [1:0] ch2_direction_select = chan[B_CH2_DIRECTION_SELECT +: 2];
  wire [2:0] ch2_output_mode = chan[B_C2MODE +: 3];
  wire [3:0] ch1_input_filter = chan[B_C1DF +: 4];
  wire counter_enable = ctrl[B_COUNTER_ENABLE];

  // ****************************************************
  // Input conditioning
  // ****************************************************
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [FLT_N-1:0] flt1_hist;
  logic ch1_filt;
  logic ch1_filt_d;
  logic [3:0] etr_cnt;
  logic etr_q;
  logic etr_filt;
  logic etr_filt_d;
  logic [2:0] etr_div;

  // Two-stage resync fixes trigger latency regardless of mode
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      etr_q <= 1'b0;
    end
    else
    begin
      sync1 <= {pins_in.ext, pins_in.ch2, pins_in.ch1 ^ (ctrl[B_XOR] & (pins_in.ch2 ^ pins_in.ch3))};
      sync2 <= sync1;
      etr_q <= sync2[2];
    end
  end

  // Filter needs FLT_N equal samples; code 0000 bypasses it
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      flt1_hist <= '0;
      ch1_filt <= 1'b0;
    end
    else
    begin
      flt1_hist <= {flt1_hist[FLT_N-2:0], sync2[0]};
      if (ch1_input_filter == FLT_NONE)
        ch1_filt <= sync2[0];
      else if (&flt1_hist)
        ch1_filt <= 1'b1;
      else if (~|flt1_hist)
        ch1_filt <= 1'b0;
    end
  end

  wire ch1_pol = ch1_filt ^ chan[B_C1P];
  wire ch2_pol = sync2[1] ^ chan[B_C2P];
  // Selection 01 maps each channel to its own pin; INTERNAL_TRIGGER_CAPTURE_SOURCE capture uses trigger
  wire ch1_any_edge = ch1_filt ^ ch1_filt_d;

  // External trigger: polarity, filter by consecutive sample count, divider
  wire etr_pol = etr_q ^ ext_trigger_polarity;
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      etr_cnt <= 4'h0;
      etr_filt <= 1'b0;
      etr_filt_d <= 1'b0;
      etr_div <= 3'h0;
      ch1_filt_d <= 1'b0;
    end
    else
    begin
      if (ext_trigger_filter == FLT_NONE || etr_cnt == ext_trigger_filter)
      begin
        etr_filt <= etr_pol;
        etr_cnt <= 4'h0;
      end
      else if (etr_pol != etr_filt)
        etr_cnt <= etr_cnt + 4'h1;
      else
        etr_cnt <= 4'h0;
      etr_filt_d <= etr_filt;
      if (etr_filt & ~etr_filt_d)
        etr_div <= etr_div + 3'h1;
      ch1_filt_d <= ch1_filt;
    end
  end

  wire etr_rise = etr_filt & ~etr_filt_d;
  // Divider 00 passes every edge; 01/10/11 pass every 2nd/4th/8th
  wire ext_trigger_prescaled = etr_rise & ((ext_trigger_divider == 2'h0) |
    (ext_trigger_divider == 2'h1 & etr_div[0]) |
    (ext_trigger_divider == 2'h2 & (&etr_div[1:0])) |
    (ext_trigger_divider == 2'h3 & (&etr_div)));

  // ****************************************************
  // Trigger selection
  // ****************************************************
  logic slave_trigger_input;
  logic trig_prev;
  always_comb
  begin
    if (trigger_source_select == TRGS_CH1)
      slave_trigger_input = (slave_mode_select == SMS_RESET && ctrl[B_XOR]) ?
        ch1_any_edge : ch1_pol;
    else if (trigger_source_select == TRGS_CH2)
      slave_trigger_input = ch2_pol;
    else if (trigger_source_select == TRGS_EXT)
      slave_trigger_input = etr_filt;
    else
      slave_trigger_input = 1'b0;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      trig_prev <= 1'b0;
    else
      trig_prev <= slave_trigger_input;
  end

  wire trig_edge = (slave_mode_select == SMS_RESET && ctrl[B_XOR] &&
    trigger_source_select == TRGS_CH1) ? slave_trigger_input :
    (slave_trigger_input & ~trig_prev);
  wire reset_evt = (slave_mode_select == SMS_RESET) & trig_edge;
  wire trig_start = (slave_mode_select == SMS_TRIG) & trig_edge & ~counter_enable;
  wire gate_on = counter_enable & slave_trigger_input;
  wire gated = slave_mode_select == SMS_GATED;
  logic gate_prev;
  wire gate_change = gated & (gate_on != gate_prev);
  wire trg_event = reset_evt | trig_start | gate_change |
    ((slave_mode_select == SMS_TRIG) & trig_edge);
  wire update_evt = (reset_evt & ~ctrl[B_UPDATE_REQUEST_SOURCE]) | sw_update;

  // ****************************************************
  // Counter
  // ****************************************************
  wire run = gated ? gate_on : counter_enable;
  wire tick_src = ext_clock2_enable ? ext_trigger_prescaled : 1'b1;
  wire psc_done = psc_cnt == psc;

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count <= CNT_ZERO;
      psc_cnt <= PSC_RESET;
      gate_prev <= 1'b0;
    end
    else
    begin
      gate_prev <= gate_on;
      if (reset_evt | sw_update)
      begin
        count <= CNT_ZERO;
        psc_cnt <= PSC_RESET;
      end
      else if (run & tick_src)
      begin
        psc_cnt <= psc_done ? PSC_RESET : psc_cnt + CNT_ONE;
        if (psc_done)
          count <= (count == ar_shadow) ? CNT_ZERO : count + CNT_ONE;
      end
    end
  end

  // Shadow loads happen on an update event or when the counter wraps at ar_shadow
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ar_shadow <= AR_RESET;
      cmp2_shadow <= CMP_RESET;
    end
    else if (update_evt | (count == ar_shadow & run & tick_src & psc_done))
    begin
      ar_shadow <= ar;
      cmp2_shadow <= cmp2;
    end
  end

  // ****************************************************
  // Capture, output and control transfer
  // ****************************************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cap1 <= CNT_ZERO;
    else if (ch1_direction_select == SEL_TRC && trg_event)
      cap1 <= count;
  end

  // PWM mode 2: high once count reaches compare
  wire ch2_output_reference = (ch2_direction_select == SEL_OUT) &&
    (ch2_output_mode == OC2_PWM2) && (count >= cmp2_shadow);

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      trigger_output_out <= 1'b0;
      ch2_output_out <= 1'b0;
      trigger_irq_out <= 1'b0;
      trigger_dma_out <= 1'b0;
      channel_output_enable_out <= 4'h0;
      channel_output_mode_out <= 12'h000;
    end
    else
    begin
      ch2_output_out <= ch2_output_reference & chan[B_CH2EN];
      trigger_output_out <= (ctrl[B_MMS +: 3] == MMS_OC2) & ch2_output_reference;
      trigger_irq_out <= (status[B_TRIGGER_FLAG] | trg_event) & ctrl[B_TRIGGER_IRQ_ENABLE];
      trigger_dma_out <= trg_event & ctrl[B_TRIGGER_DMA_ENABLE];
      if (ctrl[B_CPC] && ((ctrl[B_CTRL_UPDATE_SOURCE] && trg_event) || sw_update))
      begin
        channel_output_enable_out <= chan[B_CHEN_PRE +: 4];
        channel_output_mode_out <= chan[B_CHMODE_PRE +: 12];
      end
      else if (!ctrl[B_CPC])
      begin
        channel_output_enable_out <= chan[B_CHEN_PRE +: 4];
        channel_output_mode_out <= chan[B_CHMODE_PRE +: 12];
      end
    end
  end

  // ****************************************************
  // AXI4-Lite slave
  // ****************************************************
  bus_state_t wr_state;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire do_write = aw_held & w_held & (wr_state == BUS_IDLE);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
    input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = val[i*8 +: 8];
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a <= ADDR_EVGEN && a[1:0] == 2'h0;
  endfunction

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_state <= BUS_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= WORD_ZERO;
      w_strb <= 4'h0;
      awready_out <= 1'b0;
      wready_out <= 1'b0;
      bvalid_out <= 1'b0;
      bresp_out <= RESP_OK;
    end
    else
    begin
      awready_out <= ~aw_held & ~awready_out & awvalid_in & (wr_state == BUS_IDLE);
      wready_out <= ~w_held & ~wready_out & wvalid_in & (wr_state == BUS_IDLE);
      if (awvalid_in & awready_out)
      begin
        aw_held <= 1'b1;
        aw_addr <= awaddr_in;
      end
      if (wvalid_in & wready_out)
      begin
        w_held <= 1'b1;
        w_data <= wdata_in;
        w_strb <= wstrb_in;
      end
      case (wr_state)
        BUS_IDLE:
          if (do_write)
          begin
            wr_state <= BUS_RESP;
            bvalid_out <= 1'b1;
            bresp_out <= mapped(aw_addr) ? RESP_OK : RESP_ERR;
            aw_held <= 1'b0;
            w_held <= 1'b0;
          end
        default:
          if (bready_in)
          begin
            bvalid_out <= 1'b0;
            wr_state <= BUS_IDLE;
          end
      endcase
    end
  end

  // Old value of the addressed register, so byte lanes merge into it
  logic [31:0] wr_old;
  logic [31:0] wr_word;
  always_comb
  begin
    if (aw_addr == ADDR_CTRL)
      wr_old = {22'h0, ctrl};
    else if (aw_addr == ADDR_SLAVE)
      wr_old = {16'h0, slave};
    else if (aw_addr == ADDR_CHAN)
      wr_old = chan;
    else if (aw_addr == ADDR_PSC)
      wr_old = {16'h0, psc};
    else if (aw_addr == ADDR_AR)
      wr_old = {16'h0, ar};
    else if (aw_addr == ADDR_CMP2)
      wr_old = {16'h0, cmp2};
    else
      wr_old = WORD_ZERO;
    wr_word = merge(wr_old, w_data, w_strb);
  end

  // Register writes; hardware flag set wins over software clear
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl <= 10'h000;
      slave <= 16'h0000;
      chan <= WORD_ZERO;
      status <= 2'h0;
      psc <= PSC_RESET;
      ar <= AR_RESET;
      cmp2 <= CMP_RESET;
      sw_update <= 1'b0;
    end
    else
    begin
      sw_update <= do_write && aw_addr == ADDR_EVGEN && w_strb[0] && w_data[0];
      if (do_write)
      begin
        if (aw_addr == ADDR_CTRL)
          ctrl <= wr_word[9:0];
        else if (aw_addr == ADDR_SLAVE)
          slave <= wr_word[15:0];
        else if (aw_addr == ADDR_CHAN)
          chan <= wr_word;
        else if (aw_addr == ADDR_STATUS && w_strb[0])
          status <= status & w_data[1:0];
        else if (aw_addr == ADDR_PSC)
          psc <= wr_word[15:0];
        else if (aw_addr == ADDR_AR)
          ar <= wr_word[15:0];
        else if (aw_addr == ADDR_CMP2)
          cmp2 <= wr_word[15:0];
      end
      if (trig_start)
        ctrl[B_COUNTER_ENABLE] <= 1'b1;
      if (trg_event)
        status[B_TRIGGER_FLAG] <= 1'b1;
      if (ch1_direction_select == SEL_TRC && trg_event)
        status[B_CAP1IF] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= WORD_ZERO;
      rresp_out <= RESP_OK;
    end
    else
    begin
      arready_out <= arvalid_in & ~arready_out & ~rvalid_out;
      if (arvalid_in & arready_out)
      begin
        rvalid_out <= 1'b1;
        rresp_out <= mapped(araddr_in) ? RESP_OK : RESP_ERR;
        if (araddr_in == ADDR_CTRL)
          rdata_out <= {22'h0, ctrl};
        else if (araddr_in == ADDR_SLAVE)
          rdata_out <= {16'h0, slave};
        else if (araddr_in == ADDR_CHAN)
          rdata_out <= chan;
        else if (araddr_in == ADDR_STATUS)
          rdata_out <= {30'h0, status};
        else if (araddr_in == ADDR_COUNT)
          rdata_out <= {16'h0, count};
        else if (araddr_in == ADDR_PSC)
          rdata_out <= {16'h0, psc};
        else if (araddr_in == ADDR_AR)
          rdata_out <= {16'h0, ar};
        else if (araddr_in == ADDR_CMP2)
          rdata_out <= {16'h0, cmp2};
        else if (araddr_in == ADDR_CAP1)
          rdata_out <= {16'h0, cap1};
        else
          rdata_out <= WORD_ZERO;
      end
      else if (rvalid_out & rready_in)
        rvalid_out <= 1'b0;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  AST_RESET_CLEARS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    reset_evt |=> count == CNT_ZERO) else $error("reset trigger did not clear counter");
  AST_TRG_FLAG: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    trg_event |=> status[B_TRIGGER_FLAG]) else $error("trigger flag not set");
  AST_GATE_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (gated && !counter_enable && !sw_update) |=> count == $past(count))
    else $error("gated counter moved while disabled");
  AST_TRIG_START: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    trig_start |=> counter_enable) else $error("trigger mode did not start counter");
  AST_TRIGGER_OUTPUT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (ctrl[B_MMS +: 3] == MMS_OC2) |=> trigger_output_out == $past(ch2_output_reference))
    else $error("trigger output not channel 2 reference");
  AST_CAPTURE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (ch1_direction_select == SEL_TRC && trg_event) |=> cap1 == $past(count))
    else $error("capture missed trigger");
  AST_ANY_EDGE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $changed(ch1_filt) |-> ch1_any_edge ##1 (ch1_any_edge == $changed(ch1_filt)))
    else $error("any-edge pulse wrong");
  AST_XOR_IN: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    ctrl[B_XOR] |=> sync1[0] == ($past(pins_in.ch1) ^ $past(pins_in.ch2) ^ $past(pins_in.ch3)))
    else $error("input xor wrong");
  AST_GATE_FLAG: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    gate_change |=> status[B_TRIGGER_FLAG]) else $error("gate change flag missing");
endmodule

// ==== tmr_slave_pkg.sv ====
// Operation
// - Input-XOR select feeds channel 1 filter with XOR of three channel pins.
// - Reset mode on channel 1 any-edge: every Hall toggle restarts counter at 0.
// - Channel 1 selection 11 captures counter on internal trigger signal.
// - Channel 2 mode 111 is PWM mode 2; selection 00 makes channel 2 output.
// - Master select 101 routes channel 2 reference to trigger output.
// - With preload and update source set, trigger input transfers preloaded control bits.
// - Reset-mode trigger reinitialises counter, prescaler; update event when request source low.
// - Slave mode 100 is reset mode: counter cleared and restarted on trigger.
// - Trigger source 101 picks filtered channel 1, 110 picks unfiltered channel 2.
// - Trigger event sets trigger flag; requests interrupt or DMA when enabled.
// - Trigger latency is fixed by input resynchronisation stage.
// - Slave mode 101 is gated mode: count while trigger level active.
// - Gated mode never counts while counter enable is 0.
// - Gated mode sets trigger flag on both start and stop.
// - Slave mode 110 is trigger mode: active edge sets counter enable.
// - Polarity 0 keeps rising/high active, 1 inverts input.
// - External clock mode 2 combines with reset, gated or trigger mode.
// - External trigger: filter, divider, polarity and clock-2 enable supported.
// - Clock mode 2 plus trigger mode: edge enables, then count per external edge.
// - Channel filter code 0000 passes input unfiltered.
// - Selection 01 maps each channel to its own pin.
package tmr_slave_pkg;
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] AR_RESET = 16'hffff;
  localparam logic [CNT_W-1:0] CMP_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] PSC_RESET = 16'h0000;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SLAVE = 8'h04;
  localparam logic [7:0] ADDR_CHAN = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_PSC = 8'h14;
  localparam logic [7:0] ADDR_AR = 8'h18;
  localparam logic [7:0] ADDR_CMP2 = 8'h1c;
  localparam logic [7:0] ADDR_CAP1 = 8'h20;
  localparam logic [7:0] ADDR_EVGEN = 8'h24;

  // CTRL fields
  localparam int unsigned B_COUNTER_ENABLE = 0;
  localparam int unsigned B_UPDATE_REQUEST_SOURCE = 1;
  localparam int unsigned B_XOR = 2;
  localparam int unsigned B_CPC = 3;
  localparam int unsigned B_CTRL_UPDATE_SOURCE = 4;
  localparam int unsigned B_MMS = 5;
  localparam int unsigned B_TRIGGER_IRQ_ENABLE = 8;
  localparam int unsigned B_TRIGGER_DMA_ENABLE = 9;
  // SLAVE fields
  localparam int unsigned B_SMS = 0;
  localparam int unsigned B_TRGS = 4;
  localparam int unsigned B_EXT_TRIGGER_FILTER = 8;
  localparam int unsigned B_ETD = 12;
  localparam int unsigned B_ETP = 14;
  localparam int unsigned B_ECLK = 15;
  // CHAN fields
  localparam int unsigned B_CH1_DIRECTION_SELECT = 0;
  localparam int unsigned B_C1P = 2;
  localparam int unsigned B_C1DF = 4;
  localparam int unsigned B_CH2_DIRECTION_SELECT = 8;
  localparam int unsigned B_C2P = 10;
  localparam int unsigned B_C2MODE = 12;
  localparam int unsigned B_CH2EN = 15;
  localparam int unsigned B_CHEN_PRE = 16;
  localparam int unsigned B_CHMODE_PRE = 20;
  // STATUS fields
  localparam int unsigned B_TRIGGER_FLAG = 0;
  localparam int unsigned B_CAP1IF = 1;

  localparam logic [2:0] SMS_RESET = 3'h4;
  localparam logic [2:0] SMS_GATED = 3'h5;
  localparam logic [2:0] SMS_TRIG = 3'h6;
  localparam logic [2:0] TRGS_CH1 = 3'h5;
  localparam logic [2:0] TRGS_CH2 = 3'h6;
  localparam logic [2:0] TRGS_EXT = 3'h7;
  localparam logic [2:0] MMS_OC2 = 3'h5;
  localparam logic [2:0] OC2_PWM2 = 3'h7;
  localparam logic [1:0] SEL_OUT = 2'h0;
  localparam logic [1:0] SEL_OWN = 2'h1;
  localparam logic [1:0] SEL_TRC = 2'h3;
  localparam logic [3:0] FLT_NONE = 4'h0;
  localparam int unsigned FLT_N = 8;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  typedef struct packed {
    logic ch1;
    logic ch2;
    logic ch3;
    logic ext;
  } pins_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RESP = 2'b01
  } bus_state_t;
endpackage

// ==== hall_model.sv ====
`timescale 1ns/100ps
module hall_model
(
  input wire logic clk_sys_in,
  output tmr_slave_pkg::pins_t pins_out
);
  import tmr_slave_pkg::*;
  // ***********
  // Sensor pins
  // ***********
  // Pins idle low; levels change only after a clock edge
  initial pins_out = '0;
  // Never selects the external pin as trigger while it clocks
  task automatic put(input pins_t v);
    @(posedge clk_sys_in);
    pins_out <= v;
  endtask
endmodule

// ==== tb_timer_slave_mode_control.sv ====
`timescale 1ns/100ps
module tb_timer_slave_mode_control;
  import tmr_slave_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pins_t pins;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, trg_irq, trg_out, trg_dma, ch2_out;
  logic [3:0] chen;
  logic [11:0] chmode;
  logic [1:0] bresp, rresp;
  int bad_count = 0, n_tests = 0, cycles = 0;
  logic [31:0] a, b;
  always #5 clk = ~clk;
  hall_model PM (.clk_sys_in(clk), .pins_out(pins));
  tmr_slave_ctrl DUT (.clk_sys_in(clk), .rst_n_in(rst_n), .pins_in(pins),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
    .wdata_in(wdata), .wstrb_in(4'hf), .wvalid_in(wvalid), .wready_out(wready),
    .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
    .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready),
    .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready),
    .trigger_output_out(trg_out), .trigger_irq_out(trg_irq), .trigger_dma_out(trg_dma),
    .ch2_output_out(ch2_out), .channel_output_enable_out(chen),
    .channel_output_mode_out(chmode));
  // *******************
  // Bus and check tasks
  // *******************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
    end while (bvalid !== 1'b1);
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 0;
  endtask
  task automatic setup(input logic [31:0] c, input logic [31:0] ch, input logic [31:0] s);
    wr(ADDR_CTRL, c);
    wr(ADDR_CHAN, ch);
    wr(ADDR_SLAVE, s);
    repeat (20) @(posedge clk);
  endtask
  // *********
  // Scenarios
  // *********
  task automatic t_reset_values();
    rd(ADDR_AR, a);
    chk(a, 32'h0000ffff);
    rd(8'h28, a);
    chk({a[29:0], rresp}, 32'h2); // Unmapped place refused
  endtask
  task automatic t_reset_mode();
    setup(32'h101, 32'h1, 32'h54);
    PM.put(4'b1000);
    repeat (6) @(posedge clk);
    rd(ADDR_COUNT, a);
    chk(a < 32'd12, 1);
    rd(ADDR_STATUS, a);
    chk(a[0], 1);
    chk(trg_irq, 1);
    wr(ADDR_STATUS, WORD_ZERO);
    @(posedge clk);
    chk(trg_irq, 0);
  endtask
  task automatic t_xor_hall();
    setup(32'h5, 32'h1, 32'h54);
    PM.put(4'b1010);
    repeat (6) @(posedge clk);
    rd(ADDR_COUNT, a);
    chk(a < 32'd12, 1);
  endtask
  task automatic t_gated();
    setup(32'h0, 32'h5, 32'h55);
    PM.put(4'b0000);
    repeat (8) @(posedge clk);
    rd(ADDR_COUNT, a);
    rd(ADDR_COUNT, b);
    chk(b, a);
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_COUNT, a);
    chk(a > b, 1);
    wr(ADDR_STATUS, WORD_ZERO);
    PM.put(4'b1000);
    repeat (8) @(posedge clk);
    rd(ADDR_COUNT, a);
    rd(ADDR_COUNT, b);
    chk(b, a);
    rd(ADDR_STATUS, a);
    chk(a[0], 1);
  endtask
  task automatic t_trigger();
    setup(32'h0, 32'h100, 32'h66);
    PM.put(4'b0100);
    repeat (8) @(posedge clk);
    rd(ADDR_CTRL, a);
    chk(a[0], 1);
    rd(ADDR_COUNT, a);
    rd(ADDR_COUNT, b);
    chk(b > a, 1);
  endtask
  // Hall changes 17 cycles apart, so the capture holds 16
  task automatic t_hall();
    wr(ADDR_CMP2, 32'h8);
    setup(32'h2bd, 32'h1235f003, 32'h54);
    chk(chen, 4'h0);
    PM.put(4'b1100);
    repeat (5) @(posedge clk);
    chk(trg_dma, 1);
    @(posedge clk);
    chk(trg_dma, 0);
    chk(trg_out, 0);
    chk(chen, 4'h5);
    chk(chmode, 12'h123);
    repeat (10) @(posedge clk);
    chk(trg_out, 1);
    chk(ch2_out, 1);
    PM.put(4'b1110);
    repeat (6) @(posedge clk);
    rd(ADDR_CAP1, a);
    chk(a, 32'h10);
  endtask
  // External pulses before the trigger must not count
  task automatic t_ext_clock();
    PM.put(4'b0000);
    setup(32'h0, 32'h1, 32'h8056);
    rd(ADDR_COUNT, a);
    repeat (2)
    begin
      PM.put(4'b0001);
      PM.put(4'b0000);
    end
    repeat (4) @(posedge clk);
    PM.put(4'b1000);
    repeat (6) @(posedge clk);
    rd(ADDR_CTRL, b);
    chk(b[0], 1);
    repeat (4)
    begin
      PM.put(4'b1001);
      PM.put(4'b1000);
    end
    repeat (6) @(posedge clk);
    rd(ADDR_COUNT, b);
    chk(b, a + 32'h4);
  endtask
  // *******
  // Closing
  // *******
  task automatic end_of_test();
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Whole run needs well under 2000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_reset_mode();
    t_xor_hall();
    t_gated();
    t_trigger();
    t_hall();
    t_ext_clock();
    end_of_test();
  end
endmodule
